// >>> common/sata_port_pkg.sv
// Purpose: shared constants for the sata port pll recovery block
// Assumes: single 10 MHz clock, synchronous active-low reset
// Notes:   bit positions follow the port command, status and error words
package sata_port_pkg;
   // ==========================================================
   // command word bit positions
   localparam int CMD_SPIN_UP_BIT     = 1;
   localparam int CMD_ALPM_EN_BIT     = 26;
   localparam int CMD_ALPM_SLUMBER    = 27;
   // ==========================================================
   // interrupt status, task file, error and pll go bit positions
   localparam int IS_PIO_SETUP_BIT    = 1;
   localparam int IS_IF_FATAL_BIT     = 27;
   localparam int TFD_BUSY_BIT        = 7;
   localparam int TFD_DRQ_BIT         = 3;
   localparam int SERR_LINK_SEQ_BIT   = 23;
   localparam int PLL_GO_BIT          = 0;
   // ==========================================================
   // port reset detection field
   localparam logic [3:0] DET_COMRESET = 4'h1;
   // ==========================================================
   // fis types and limits
   localparam logic [7:0] FIS_REG_D2H    = 8'h34;
   localparam logic [7:0] FIS_PIO_SETUP  = 8'h5F;
   localparam int         REG_FIS_DWORDS = 8;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS   = 100;
   localparam int RELOCK_TIME_NS  = 1000;
   localparam int RELOCK_CYCLES   = (RELOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ==========================================================
   // reset values
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
   // ==========================================================
   // physical interface power states
   typedef enum logic [1:0] {PHY_ACTIVE, PHY_PARTIAL, PHY_SLUMBER} phy_power_t;
endpackage : sata_port_pkg

// >>> core/pll_lock_timer.sv
// Purpose: models lock acquisition of the sata pll after go is raised
// Assumes: go and soft reset are synchronous to clk
// Notes:   lock drops on the next clock edge when go falls or soft reset is high
`timescale 1ns/100ps
`default_nettype none
module pll_lock_timer
   import sata_port_pkg::*;
#(
   parameter int LOCK_CYCLES = RELOCK_CYCLES
)(
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic go,
   input  wire logic soft_reset,
   output logic      locked
);
   logic [15:0] count_q;
   logic [15:0] count_d;
   logic        locked_q;
   logic        locked_d;

   always_comb
   begin
      count_d  = count_q;
      locked_d = locked_q;
      if (!go || soft_reset)
      begin
         count_d  = 16'h0000;
         locked_d = 1'b0;
      end
      else if (!locked_q)
      begin
         if (count_q == 16'(LOCK_CYCLES - 1))
            locked_d = 1'b1;
         else
            count_d = count_q + 16'h0001;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         count_q  <= 16'h0000;
         locked_q <= 1'b0;
      end
      else
      begin
         count_q  <= count_d;
         locked_q <= locked_d;
      end
   end

   assign locked = locked_q;
endmodule : pll_lock_timer
`default_nettype wire

// >>> core/sata_port_pll_recovery.sv
// Purpose: sata host port slice: power, pll relock, receive status, errors
// Assumes: fis words arrive as a one-cycle valid stream from the link layer
// Notes:   control and status bits are plain ports, no register bus
// Notes on behaviour
// RQ1: software enables phys, starts dma, then sets spin-up bit to one.
// RQ2: aggressive power management enabled by bit 26, bit 27 picks slumber.
// RQ3: with aggressive mode and no commands, only phy lines enter low power.
// RQ4: software stops dma, clears spin-up and powers phys down before pll work.
// RQ5: pll go low unlocks, go high relocks, then the port leaves low power.
// RQ6: software unlocks pll then pulses soft reset so later spin-up works.
// RQ7: received pio setup fis sets pio setup status bit.
// RQ8: pio setup with busy and drq clear must not hang the port.
// RQ9: software reset uses two register fises with srst set then cleared.
// RQ10: port reset writes one into detection field.
// RQ11: software times out stalls, tries software reset, then port reset.
// RQ12: illegal link sequence sets interface fatal and link sequence error.
// RQ13: with both error flags set, software must use port reset.
// RQ14: register fis over eight dwords is an error, no fifo overflow.
// RQ15: after oversized register fis stall, software issues port reset.
// RQ16: pll soft reset high holds pll-derived clocking logic in reset.
`timescale 1ns/100ps
`default_nettype none
module sata_port_pll_recovery
   import sata_port_pkg::*;
#(
   parameter int LOCK_CYCLES = RELOCK_CYCLES,
   parameter int MAX_DWORDS  = REG_FIS_DWORDS
)(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        spin_up,
   input  wire logic        alpm_enable,
   input  wire logic        alpm_slumber,
   input  wire logic        cmds_pending,
   input  wire logic        pll_go,
   input  wire logic        pll_soft_reset_bit,
   input  wire logic [3:0]  det_ctrl,
   input  wire logic        fis_valid,
   input  wire logic        fis_sof,
   input  wire logic        fis_eof,
   input  wire logic [31:0] fis_data,
   input  wire logic        link_seq_error,
   input  wire logic        pio_status_clear,
   input  wire logic        fatal_status_clear,
   input  wire logic        serr_clear,
   output logic             phy_partial,
   output logic             phy_slumber,
   output logic             link_active,
   output logic             pio_setup_status,
   output logic             if_fatal_status,
   output logic             link_seq_err_status,
   output logic             oversize_err_status,
   output logic [7:0]       task_status,
   output logic             comreset_out,
   output logic             pll_domain_reset
);
   // ==========================================================
   // pll lock
   logic pll_locked;
   pll_lock_timer #(.LOCK_CYCLES(LOCK_CYCLES)) u_lock (
      .clk        (clk),
      .reset_n    (reset_n),
      .go         (pll_go),
      .soft_reset (pll_soft_reset_bit),
      .locked     (pll_locked)
   );

   // ==========================================================
   // power state
   phy_power_t pwr_q;
   phy_power_t pwr_d;
   logic       was_unlocked_q;
   logic       was_unlocked_d;
   logic       link_active_q;
   logic       link_active_d;
   logic       pll_rst_q;
   logic       pll_rst_d;

   always_comb
   begin
      pwr_d          = pwr_q;
      was_unlocked_d = was_unlocked_q | ~pll_locked;
      link_active_d  = spin_up & pll_locked & ~pll_rst_q;
      pll_rst_d      = pll_soft_reset_bit | ~pll_locked;  // see RQ16
      if (was_unlocked_q && pll_locked)
      begin
         pwr_d          = PHY_ACTIVE;  // see RQ5
         was_unlocked_d = 1'b0;
      end
      else if (alpm_enable && !cmds_pending && spin_up)  // see RQ3
         pwr_d = alpm_slumber ? PHY_SLUMBER : PHY_PARTIAL;  // see RQ2
      else if (cmds_pending || !alpm_enable)
         pwr_d = PHY_ACTIVE;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         pwr_q          <= PHY_ACTIVE;
         was_unlocked_q <= 1'b0;
         link_active_q  <= 1'b0;
         pll_rst_q      <= 1'b1;
      end
      else
      begin
         pwr_q          <= pwr_d;
         was_unlocked_q <= was_unlocked_d;
         link_active_q  <= link_active_d;
         pll_rst_q      <= pll_rst_d;
      end
   end

   // ==========================================================
   // receive fis parser
   logic [7:0] fis_type_q;
   logic [7:0] fis_type_d;
   logic [7:0] dw_cnt_q;
   logic [7:0] dw_cnt_d;
   logic       drop_q;
   logic       drop_d;
   logic       pio_ev;
   logic       over_ev;
   logic [7:0] tfd_q;
   logic [7:0] tfd_d;
   logic [7:0] cur_type;
   logic       rx_ok;

   always_comb
   begin
      fis_type_d = fis_type_q;
      dw_cnt_d   = dw_cnt_q;
      drop_d     = drop_q;
      tfd_d      = tfd_q;
      pio_ev     = 1'b0;
      over_ev    = 1'b0;
      rx_ok      = fis_valid & ~pll_rst_q;  // see RQ16
      cur_type   = fis_sof ? fis_data[7:0] : fis_type_q;
      if (rx_ok)
      begin
         if (fis_sof)
         begin
            fis_type_d = fis_data[7:0];
            dw_cnt_d   = 8'h01;
            drop_d     = 1'b0;
            tfd_d      = fis_data[23:16];
         end
         else if (!drop_q)
            dw_cnt_d = dw_cnt_q + 8'h01;
         // oversized register fis: stop counting, drop tail words
         if (cur_type == FIS_REG_D2H && !fis_sof && !drop_q
             && dw_cnt_q >= 8'(MAX_DWORDS))
         begin
            drop_d  = 1'b1;  // see RQ14
            over_ev = 1'b1;  // see RQ14
         end
         // pio setup completes whatever the busy and drq bits say
         if (fis_eof && cur_type == FIS_PIO_SETUP)
            pio_ev = 1'b1;  // see RQ7, RQ8
         if (fis_eof)
         begin
            fis_type_d = 8'h00;
            dw_cnt_d   = 8'h00;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n || pll_rst_q)
      begin
         fis_type_q <= 8'h00;
         dw_cnt_q   <= 8'h00;
         drop_q     <= 1'b0;
         tfd_q      <= 8'h00;
      end
      else
      begin
         fis_type_q <= fis_type_d;
         dw_cnt_q   <= dw_cnt_d;
         drop_q     <= drop_d;
         tfd_q      <= tfd_d;
      end
   end

   // ==========================================================
   // sticky status, set wins over clear
   logic [3:0]  sts_q;
   logic [3:0]  sts_d;
   logic [3:0]  sts_set;
   logic [3:0]  sts_clr;
   logic        comreset_q;
   logic        comreset_d;

   always_comb
   begin
      sts_set    = {over_ev, link_seq_error, link_seq_error, pio_ev};  // see RQ12
      sts_clr    = {fatal_status_clear, serr_clear, fatal_status_clear, pio_status_clear};
      sts_d      = (sts_q & ~sts_clr) | sts_set;
      comreset_d = (det_ctrl == DET_COMRESET);
      if (comreset_q)
         sts_d = sts_set;  // port reset clears error state
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         sts_q      <= 4'h0;
         comreset_q <= 1'b0;
      end
      else
      begin
         sts_q      <= sts_d;
         comreset_q <= comreset_d;
      end
   end

   // ==========================================================
   // outputs
   logic phy_partial_q;
   logic phy_slumber_q;
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         phy_partial_q <= 1'b0;
         phy_slumber_q <= 1'b0;
      end
      else
      begin
         phy_partial_q <= (pwr_d == PHY_PARTIAL);
         phy_slumber_q <= (pwr_d == PHY_SLUMBER);
      end
   end

   assign phy_partial         = phy_partial_q;
   assign phy_slumber         = phy_slumber_q;
   assign link_active         = link_active_q;
   assign pio_setup_status    = sts_q[0];
   assign if_fatal_status     = sts_q[1];
   assign link_seq_err_status = sts_q[2];
   assign oversize_err_status = sts_q[3];
   assign task_status         = tfd_q;
   assign comreset_out        = comreset_q;
   assign pll_domain_reset    = pll_rst_q;
endmodule : sata_port_pll_recovery
`default_nettype wire

// >>> verification/sata_port_pll_recovery_assertions.sv
// Purpose: port-level checks for the sata port pll recovery block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound from tb_top; frame type and length tracked locally
`timescale 1ns/100ps
`default_nettype none
module sata_port_pll_recovery_checker
   import sata_port_pkg::*;
#(
   parameter int LOCK_CYCLES = RELOCK_CYCLES,
   parameter int MAX_DWORDS  = REG_FIS_DWORDS
)(
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        alpm_enable,
   input wire logic        alpm_slumber,
   input wire logic        cmds_pending,
   input wire logic        pll_soft_reset_bit,
   input wire logic [3:0]  det_ctrl,
   input wire logic        fis_valid,
   input wire logic        fis_sof,
   input wire logic        fis_eof,
   input wire logic [31:0] fis_data,
   input wire logic        link_seq_error,
   input wire logic        fatal_status_clear,
   input wire logic        phy_partial,
   input wire logic        phy_slumber,
   input wire logic        pio_setup_status,
   input wire logic        if_fatal_status,
   input wire logic        link_seq_err_status,
   input wire logic        oversize_err_status,
   input wire logic        comreset_out,
   input wire logic        pll_domain_reset
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   logic [7:0]  type_q;
   logic [7:0]  type_d;
   int unsigned cnt_q;
   int unsigned cnt_d;
   logic        quiet;
   // ==========================================================
   // frame tracking
   assign quiet = !pll_domain_reset && !comreset_out && det_ctrl != DET_COMRESET;
   always_comb
   begin
      type_d = type_q;
      cnt_d  = cnt_q;
      if (fis_valid && fis_sof)
      begin
         type_d = fis_data[7:0];
         cnt_d  = 1;
      end
      else if (fis_valid)
         cnt_d = cnt_q + 1;
   end
   always_ff @(posedge clk)
   begin
      type_q <= reset_n ? type_d : 8'h00;
      cnt_q  <= reset_n ? cnt_d : 0;
   end
   // ==========================================================
   // properties
   sequence s_pio_end;
      fis_valid && fis_eof && !fis_sof && type_q == FIS_PIO_SETUP && quiet;
   endsequence
   sequence s_reg_long_end;
      fis_valid && fis_eof && type_q == FIS_REG_D2H && cnt_q >= MAX_DWORDS && quiet;
   endsequence
   a_pio_status_set: assert property (s_pio_end |=> pio_setup_status)
      else $error("pio setup status not set after frame");
   a_oversize_flag: assert property (s_reg_long_end |=> oversize_err_status)
      else $error("long register frame not flagged");
   a_fatal_pair: assert property (link_seq_error && quiet |=> if_fatal_status && link_seq_err_status)
      else $error("link fault flags not both set");
   a_fatal_sticky: assert property (if_fatal_status && !fatal_status_clear && quiet |=> if_fatal_status)
      else $error("fatal flag dropped without clear");
   a_comreset_follow: assert property (1'b1 |=> comreset_out == ($past(det_ctrl) == DET_COMRESET))
      else $error("port reset output does not follow detection field");
   a_soft_rst_hold: assert property (pll_soft_reset_bit |=> pll_domain_reset)
      else $error("pll domain not held in reset");
   a_power_cause: assert property ((phy_partial || phy_slumber) |-> $past(alpm_enable) && !$past(cmds_pending))
      else $error("low power without idle aggressive mode");
   a_slumber_select: assert property ((phy_partial || phy_slumber) |-> phy_slumber == $past(alpm_slumber) && phy_partial != phy_slumber)
      else $error("wrong low power target");
endmodule : sata_port_pll_recovery_checker
`default_nettype wire

// >>> verification/sata_drive_model.sv
// Purpose: drive-side frame source facing the port receive stream
// Assumes: words launched on falling clock edges
// Notes:   data shows the inverted last word between frames
`timescale 1ns/100ps
`default_nettype none
module sata_drive_model (
   input  wire logic   clk,
   output logic        fis_valid,
   output logic        fis_sof,
   output logic        fis_eof,
   output logic [31:0] fis_data
);
   initial
   begin
      fis_valid = 1'b0;
      fis_sof   = 1'b0;
      fis_eof   = 1'b0;
      fis_data  = 32'h0000_0000;
   end
   // header word: type in byte0, status in byte2
   task automatic send_fis(input logic [7:0] typ, input logic [7:0] sts, input int n);
      for (int i = 0; i < n; i++)
      begin
         @(negedge clk);
         fis_valid = 1'b1;
         fis_sof   = (i == 0);
         fis_eof   = (i == n - 1);
         fis_data  = (i == 0) ? {8'h00, sts, 8'h00, typ} : 32'hA5A5_0000 + 32'(i);
      end
      @(negedge clk);
      fis_valid = 1'b0;
      fis_sof   = 1'b0;
      fis_eof   = 1'b0;
      fis_data  = ~fis_data;
   endtask : send_fis
endmodule : sata_drive_model
`default_nettype wire

// >>> verification/tb_top.sv
// Purpose: self-checking bench for the sata port pll recovery block
// Assumes: lock count shortened to 2 cycles
// Notes:   inputs change on falling edges
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import sata_port_pkg::*;
   localparam int LOCK = 2;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        spin_up, alpm_enable, alpm_slumber, cmds_pending, pll_go, pll_soft_reset_bit;
   logic        link_seq_error, pio_status_clear, fatal_status_clear, serr_clear;
   logic [3:0]  det_ctrl;
   logic        fis_valid, fis_sof, fis_eof;
   logic [31:0] fis_data;
   logic        phy_partial, phy_slumber, link_active, pio_setup_status, if_fatal_status;
   logic        link_seq_err_status, oversize_err_status, comreset_out, pll_domain_reset;
   logic [7:0]  task_status;
   int          fail_count = 0;
   int          total_checks = 0;
   int          cycles = 0;
   always #50 clk = ~clk;
   sata_port_pll_recovery #(.LOCK_CYCLES(LOCK)) uut (.*);
   sata_drive_model drive (.*);
   // ==========================================================
   // helpers
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask : pulse
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fail_count++;
         final_report();
      end
   end
   // ==========================================================
   // tests
   initial
   begin
      {spin_up, alpm_enable, alpm_slumber, cmds_pending, pll_go, pll_soft_reset_bit} = '0;
      {link_seq_error, pio_status_clear, fatal_status_clear, serr_clear} = '0;
      det_ctrl = 4'h0;
      tick(12);
      chk(pll_domain_reset, 1'b1);
      chk({pio_setup_status, if_fatal_status, oversize_err_status}, 3'h0);
      reset_n = 1'b1;
      pll_go = 1'b1;
      tick(LOCK + 3);
      chk(pll_domain_reset, 1'b0);
      spin_up = 1'b1;
      tick(2);
      chk(link_active, 1'b1);
      $display("test bringup done");
      cmds_pending = 1'b1;
      alpm_enable = 1'b1;
      tick(3);
      chk({phy_partial, phy_slumber}, 2'b00);
      cmds_pending = 1'b0;
      tick(2);
      chk({phy_partial, phy_slumber}, 2'b10);
      alpm_slumber = 1'b1;
      tick(2);
      chk({phy_partial, phy_slumber, link_active}, 3'b011);
      alpm_enable = 1'b0;
      tick(2);
      chk({phy_partial, phy_slumber}, 2'b00);
      $display("test power done");
      drive.send_fis(FIS_PIO_SETUP, 8'h00, 2);
      chk({pio_setup_status, task_status}, 9'h100);
      pulse(pio_status_clear);
      tick(1);
      chk(pio_setup_status, 1'b0);
      drive.send_fis(FIS_PIO_SETUP, 8'h50, 2);
      chk({pio_setup_status, task_status}, 9'h150);
      drive.send_fis(FIS_REG_D2H, 8'h40, REG_FIS_DWORDS);
      chk({oversize_err_status, task_status}, 9'h040);
      drive.send_fis(FIS_REG_D2H, 8'h41, REG_FIS_DWORDS + 1);
      chk({oversize_err_status, task_status}, 9'h141);
      $display("test receive done");
      pulse(link_seq_error);
      chk({if_fatal_status, link_seq_err_status}, 2'b11);
      pulse(fatal_status_clear);
      tick(1);
      chk({if_fatal_status, link_seq_err_status}, 2'b01);
      pulse(serr_clear);
      tick(1);
      chk(link_seq_err_status, 1'b0);
      drive.send_fis(FIS_REG_D2H, 8'h42, REG_FIS_DWORDS + 1);
      chk(oversize_err_status, 1'b1);
      pulse(link_seq_error);
      // soft reset fises travel host to drive, outside this slice
      det_ctrl = DET_COMRESET;
      tick(2);
      chk(comreset_out, 1'b1);
      chk({if_fatal_status, link_seq_err_status, oversize_err_status}, 3'h0);
      det_ctrl = 4'h0;
      tick(2);
      chk(comreset_out, 1'b0);
      $display("test errors done");
      alpm_enable = 1'b1;
      pulse(pio_status_clear);
      spin_up = 1'b0;
      tick(1);
      pll_go = 1'b0;
      tick(2);
      chk({pll_domain_reset, link_active, phy_slumber}, 3'b101);
      pll_soft_reset_bit = 1'b1;
      pll_go = 1'b1;
      tick(LOCK + 3);
      drive.send_fis(FIS_PIO_SETUP, 8'h00, 2);
      chk({pll_domain_reset, pio_setup_status}, 2'b10);
      pll_soft_reset_bit = 1'b0;
      tick(LOCK + 3);
      chk(pll_domain_reset, 1'b0);
      chk({phy_partial, phy_slumber}, 2'b00);
      alpm_enable = 1'b0;
      spin_up = 1'b1;
      tick(2);
      chk({link_active, phy_partial, phy_slumber}, 3'b100);
      $display("test relock done");
      final_report();
   end
endmodule : tb_top
bind sata_port_pll_recovery sata_port_pll_recovery_checker
   #(.LOCK_CYCLES(LOCK_CYCLES), .MAX_DWORDS(MAX_DWORDS)) chk_i (.*);
`default_nettype wire
